// [irq_pkg.sv]
// Package of register map, field positions and carrier types for the interrupt controller
package irq_pkg;
    // Register indexes; byte address on the bus is four times the index
    localparam logic [7:0] IDX_PORT_FLAGS = 8'h85;
    localparam logic [7:0] IDX_TIMER_EXTPIN_CONTROL = 8'h88;
    localparam logic [7:0] IDX_PORT_SEL = 8'h91;
    localparam logic [7:0] IDX_SHARED = 8'h95;
    localparam logic [7:0] IDX_PIN_FLAGS = 8'h96;
    localparam logic [7:0] IDX_EN_PRI = 8'hA8;
    localparam logic [7:0] IDX_EN_SEC = 8'hA9;
    localparam logic [7:0] IDX_PL_PRI = 8'hB8;
    localparam logic [7:0] IDX_PH_PRI = 8'hB9;
    localparam logic [7:0] IDX_PL_SEC = 8'hBA;
    localparam logic [7:0] IDX_PH_SEC = 8'hBB;
    localparam logic [7:0] IDX_LVD = 8'hBF;
    localparam logic [7:0] IDX_MODE_BASE = 8'hC0;
    localparam logic [7:0] IDX_MODE_LAST = 8'hC3;
    // Field positions
    localparam int TIMER_EXTPIN_CONTROL_TF1 = 7;
    localparam int TIMER_EXTPIN_CONTROL_TR1 = 6;
    localparam int TIMER_EXTPIN_CONTROL_TF0 = 5;
    localparam int TIMER_EXTPIN_CONTROL_TR0 = 4;
    localparam int TIMER_EXTPIN_CONTROL_IE1 = 3;
    localparam int TIMER_EXTPIN_CONTROL_IT1 = 2;
    localparam int TIMER_EXTPIN_CONTROL_IE0 = 1;
    localparam int TIMER_EXTPIN_CONTROL_IT0 = 0;
    localparam int EN_GATE = 7;
    localparam int EN_EX1 = 2;
    localparam int EN_EX0 = 0;
    localparam int SEC_PCIE = 1;
    localparam int SEC_PWM = 7;
    localparam int SH_LOW_VOLTAGE_FLAG = 7;
    localparam int SH_EEPIF = 6;
    localparam int SH_BUSY = 5;
    localparam int SH_ADIF = 4;
    localparam int SH_PIN_CHANGE_SUMMARY_FLAG = 1;
    localparam int SH_TF3 = 0;
    localparam int LVD_OUT = 6;
    localparam int MODE_CHG_BIT = 3;
    localparam int MODE_OUT_BIT = 1;
    // Writable masks and reset values
    localparam logic [7:0] EN_PRI_MASK = 8'hBF;
    localparam logic [7:0] PRI_PRI_MASK = 8'h3F;
    localparam logic [7:0] PORT_FLAG_MASK = 8'h0B;
    localparam logic [7:0] PORT_SEL_MASK = 8'h03;
    localparam logic [7:0] LVD_W_MASK = 8'h9F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LVD_CLEAR_VALUE = 8'h7F;
    localparam logic [1:0] PORT_ABSENT = 2'h2;
    // Sources and vectors
    localparam int NUM_SRC = 15;
    localparam int NUM_CLASSIC = 6;
    localparam int SRC_SEC_BASE = 7;
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_RESERVED = 4'h6;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    typedef struct packed {
        logic valid;
        logic [3:0] num;
        logic [15:0] vector;
    } irq_grant_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b01,
        PWR_HALT = 2'b10
    } pwr_state_t;
endpackage

// [irq_ctrl.sv]
// Interrupt enable, priority, pin-event and halt wake-up controller with APB registers
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl #(
    parameter int PORT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [3:0][PORT_W-1:0] port_pins,
    input wire logic timer0_evt,
    input wire logic timer1_evt,
    input wire logic timer3_evt,
    input wire logic adc_evt,
    input wire logic eep_done_evt,
    input wire logic eep_busy,
    input wire logic low_voltage_evt,
    input wire logic low_voltage_level,
    input wire logic uart1_req,
    input wire logic timer2_req,
    input wire logic uart2_req,
    input wire logic i2c_req,
    input wire logic [1:0] pwm_flags,
    input wire logic [1:0] pwm_chan_sub_enable,
    input wire logic cpu_ack,
    input wire logic cpu_reti,
    input wire logic power_down_request,
    output irq_pkg::irq_grant_t irq_out,
    output logic wake_out,
    output logic halt_refused,
    output logic halted,
    output logic [3:0] low_voltage_threshold,
    output logic [1:0] timer_run
);
    if (PORT_W != 8) begin : g_bad_width
        $error("irq_ctrl supports only eight pins per port");
    end

    logic [7:0] timer_extpin_control_q, en_pri_q, en_sec_q, pl_pri_q, ph_pri_q, pl_sec_q, ph_sec_q;
    logic [7:0] port_flags_q, port_sel_q, shared_q, lvd_q;
    logic [3:0][PORT_W-1:0] pin_flag_q, pins_prev_q;
    logic [3:0][PORT_W-1:0][3:0] mode_q;
    logic pin_a_prev_q, pin_b_prev_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    irq_pkg::irq_grant_t irq_q;
    logic [1:0] grant_lvl_q;
    logic [3:0] in_service_q;
    logic wake_q, refuse_q;
    irq_pkg::pwr_state_t pwr_q;

    // Bus decode
    logic [7:0] idx, wbyte, rd_byte;
    logic access, wr_fire, mapped;
    assign idx = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign access = psel && penable;
    assign wr_fire = clk_en && access && pwrite && pready_q && mapped;

    always_comb begin
        mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
        rd_byte = irq_pkg::REG_RESET;
        if (idx == irq_pkg::IDX_PORT_FLAGS) begin
            rd_byte = port_flags_q;
        end else if (idx == irq_pkg::IDX_TIMER_EXTPIN_CONTROL) begin
            rd_byte = timer_extpin_control_q;
        end else if (idx == irq_pkg::IDX_PORT_SEL) begin
            rd_byte = port_sel_q;
        end else if (idx == irq_pkg::IDX_SHARED) begin
            rd_byte = shared_q;
            rd_byte[irq_pkg::SH_BUSY] = eep_busy;
        end else if (idx == irq_pkg::IDX_PIN_FLAGS) begin
            rd_byte = pin_flag_q[port_sel_q[1:0]];
        end else if (idx == irq_pkg::IDX_EN_PRI) begin
            rd_byte = en_pri_q;
        end else if (idx == irq_pkg::IDX_EN_SEC) begin
            rd_byte = en_sec_q;
        end else if (idx == irq_pkg::IDX_PL_PRI) begin
            rd_byte = pl_pri_q;
        end else if (idx == irq_pkg::IDX_PH_PRI) begin
            rd_byte = ph_pri_q;
        end else if (idx == irq_pkg::IDX_PL_SEC) begin
            rd_byte = pl_sec_q;
        end else if (idx == irq_pkg::IDX_PH_SEC) begin
            rd_byte = ph_sec_q;
        end else if (idx == irq_pkg::IDX_LVD) begin
            rd_byte = lvd_q;
            rd_byte[irq_pkg::LVD_OUT] = low_voltage_level;
        end else if (idx >= irq_pkg::IDX_MODE_BASE && idx <= irq_pkg::IDX_MODE_LAST) begin
            rd_byte = {mode_q[port_sel_q[1:0]][{idx[1:0], 1'b1}], mode_q[port_sel_q[1:0]][{idx[1:0], 1'b0}]};
        end else begin
            mapped = 1'b0;
        end
    end

    // One wait state: ready rises in the second access cycle, so every transfer takes three edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            if (access && !pready_q) begin
                pready_q <= 1'b1;
                pslverr_q <= !mapped;
                prdata_q <= {24'h00_0000, (pwrite || !mapped) ? irq_pkg::REG_RESET : rd_byte};
            end else begin
                pready_q <= 1'b0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Plain read/write control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_pri_q <= irq_pkg::REG_RESET;
            en_sec_q <= irq_pkg::REG_RESET;
            pl_pri_q <= irq_pkg::REG_RESET;
            ph_pri_q <= irq_pkg::REG_RESET;
            pl_sec_q <= irq_pkg::REG_RESET;
            ph_sec_q <= irq_pkg::REG_RESET;
            lvd_q <= irq_pkg::REG_RESET;
            port_sel_q <= irq_pkg::REG_RESET;
        end else if (wr_fire) begin
            if (idx == irq_pkg::IDX_EN_PRI) begin
                en_pri_q <= wbyte & irq_pkg::EN_PRI_MASK;
            end else if (idx == irq_pkg::IDX_EN_SEC) begin
                en_sec_q <= wbyte;
            end else if (idx == irq_pkg::IDX_PL_PRI) begin
                pl_pri_q <= wbyte & irq_pkg::PRI_PRI_MASK;
            end else if (idx == irq_pkg::IDX_PH_PRI) begin
                ph_pri_q <= wbyte & irq_pkg::PRI_PRI_MASK;
            end else if (idx == irq_pkg::IDX_PL_SEC) begin
                pl_sec_q <= wbyte;
            end else if (idx == irq_pkg::IDX_PH_SEC) begin
                ph_sec_q <= wbyte;
            end else if (idx == irq_pkg::IDX_LVD) begin
                lvd_q <= wbyte & irq_pkg::LVD_W_MASK;
            end else if (idx == irq_pkg::IDX_PORT_SEL && (wbyte[1:0] != irq_pkg::PORT_ABSENT)) begin
                // Port 2 does not exist, so an index of 2 is ignored
                port_sel_q <= wbyte & irq_pkg::PORT_SEL_MASK;
            end
        end
    end

    // Pin modes, one nibble per pin, reached through the port index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= '0;
        end else if (wr_fire && idx >= irq_pkg::IDX_MODE_BASE && idx <= irq_pkg::IDX_MODE_LAST) begin
            mode_q[port_sel_q[1:0]][{idx[1:0], 1'b1}] <= wbyte[7:4];
            mode_q[port_sel_q[1:0]][{idx[1:0], 1'b0}] <= wbyte[3:0];
        end
    end

    // Pin change detection; only modes with the output bit clear and the change bit set take part
    logic [3:0][PORT_W-1:0] pin_chg;
    logic [3:0] port_chg;
    logic any_chg;
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                pin_chg[p][b] = (p != 2) && (port_pins[p][b] != pins_prev_q[p][b])
                    && mode_q[p][b][irq_pkg::MODE_CHG_BIT] && !mode_q[p][b][irq_pkg::MODE_OUT_BIT];
            end
            port_chg[p] = |pin_chg[p];
        end
        any_chg = |port_chg;
    end

    logic wr_shared, wr_port_flags, wr_pin_flags, clr_all_chg;
    assign wr_shared = wr_fire && idx == irq_pkg::IDX_SHARED;
    assign wr_port_flags = wr_fire && idx == irq_pkg::IDX_PORT_FLAGS;
    assign wr_pin_flags = wr_fire && idx == irq_pkg::IDX_PIN_FLAGS;
    assign clr_all_chg = wr_shared && !wbyte[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG];

    // Change flags: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle pins sit high, so a low start value would fake a change after reset
            pins_prev_q <= '1;
            pin_flag_q <= '0;
            port_flags_q <= irq_pkg::REG_RESET;
        end else if (clk_en) begin
            pins_prev_q <= port_pins;
            for (int p = 0; p < 4; p++) begin
                if (clr_all_chg) begin
                    pin_flag_q[p] <= pin_chg[p];
                end else if (wr_pin_flags && port_sel_q[1:0] == 2'(p)) begin
                    pin_flag_q[p] <= (pin_flag_q[p] & wbyte) | pin_chg[p];
                end else begin
                    pin_flag_q[p] <= pin_flag_q[p] | pin_chg[p];
                end
            end
            if (clr_all_chg) begin
                port_flags_q <= {4'h0, port_chg} & irq_pkg::PORT_FLAG_MASK;
            end else if (wr_port_flags) begin
                port_flags_q <= ((port_flags_q & wbyte) | {4'h0, port_chg}) & irq_pkg::PORT_FLAG_MASK;
            end else begin
                port_flags_q <= (port_flags_q | {4'h0, port_chg}) & irq_pkg::PORT_FLAG_MASK;
            end
        end
    end

    // Shared event flags
    logic [7:0] sh_set;
    always_comb begin
        sh_set = irq_pkg::REG_RESET;
        sh_set[irq_pkg::SH_LOW_VOLTAGE_FLAG] = low_voltage_evt;
        sh_set[irq_pkg::SH_EEPIF] = eep_done_evt;
        sh_set[irq_pkg::SH_ADIF] = adc_evt;
        sh_set[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG] = any_chg && en_sec_q[irq_pkg::SEC_PCIE];
        sh_set[irq_pkg::SH_TF3] = timer3_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_q <= irq_pkg::REG_RESET;
        end else if (clk_en) begin
            if (wr_shared) begin
                // Writing 7Fh clears only the low-voltage flag
                shared_q <= (shared_q & wbyte) | sh_set;
            end else begin
                shared_q <= shared_q | sh_set;
            end
        end
    end

    // External pin flags and trigger types
    logic ext_a_fall, ext_b_fall, ack_ext0, ack_ext1;
    assign ext_a_fall = pin_a_prev_q && !ext_irq_pin_a;
    assign ext_b_fall = pin_b_prev_q && !ext_irq_pin_b;
    assign ack_ext0 = cpu_ack && irq_q.valid && irq_q.num == irq_pkg::SRC_EXT0;
    assign ack_ext1 = cpu_ack && irq_q.valid && irq_q.num == irq_pkg::SRC_EXT1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_extpin_control_q <= irq_pkg::REG_RESET;
            pin_a_prev_q <= 1'b1;
            pin_b_prev_q <= 1'b1;
        end else if (clk_en) begin
            pin_a_prev_q <= ext_irq_pin_a;
            pin_b_prev_q <= ext_irq_pin_b;
            if (wr_fire && idx == irq_pkg::IDX_TIMER_EXTPIN_CONTROL) begin
                timer_extpin_control_q <= wbyte;
            end else begin
                if (ack_ext0) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE0] <= 1'b0;
                if (ack_ext1) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE1] <= 1'b0;
            end
            // Hardware sets override the write and the service clear
            if (ext_a_fall) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE0] <= 1'b1;
            if (ext_b_fall) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE1] <= 1'b1;
            if (timer0_evt) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TF0] <= 1'b1;
            if (timer1_evt) timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TF1] <= 1'b1;
        end
    end

    // Source requests, enables and levels
    logic [irq_pkg::NUM_SRC-1:0] req, en;
    logic [irq_pkg::NUM_SRC-1:0][1:0] lvl;
    always_comb begin
        req = '0;
        req[0] = timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IT0] ? timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE0] : !ext_irq_pin_a;
        req[1] = timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TF0];
        req[2] = timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IT1] ? timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE1] : !ext_irq_pin_b;
        req[3] = timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TF1];
        req[4] = uart1_req;
        req[5] = timer2_req;
        req[7] = shared_q[irq_pkg::SH_TF3];
        req[8] = shared_q[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG];
        req[9] = shared_q[irq_pkg::SH_LOW_VOLTAGE_FLAG];
        req[10] = shared_q[irq_pkg::SH_ADIF];
        req[11] = shared_q[irq_pkg::SH_EEPIF];
        req[12] = uart2_req;
        req[13] = i2c_req;
        req[14] = |(pwm_flags & pwm_chan_sub_enable);
        en = '0;
        lvl = '0;
        for (int i = 0; i < irq_pkg::NUM_CLASSIC; i++) begin
            en[i] = en_pri_q[i];
            lvl[i] = {ph_pri_q[i], pl_pri_q[i]};
        end
        for (int i = 0; i < 8; i++) begin
            en[irq_pkg::SRC_SEC_BASE + i] = en_sec_q[i];
            lvl[irq_pkg::SRC_SEC_BASE + i] = {ph_sec_q[i], pl_sec_q[i]};
        end
    end

    // Arbitration: scan downward so that ties settle on the lowest number
    logic found, preempt_ok, have_active;
    logic [3:0] best_num;
    logic [1:0] best_lvl, top_active;
    always_comb begin
        found = 1'b0;
        best_num = 4'h0;
        best_lvl = 2'h0;
        for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && en[i] && (!found || lvl[i] >= best_lvl)) begin
                found = 1'b1;
                best_num = 4'(i);
                best_lvl = lvl[i];
            end
        end
        have_active = |in_service_q;
        top_active = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (in_service_q[l]) top_active = 2'(l);
        end
        preempt_ok = !have_active || (best_lvl > top_active);
    end

    // Request to the core; withdrawn in the cycle after an acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= '0;
            grant_lvl_q <= 2'h0;
        end else if (clk_en) begin
            irq_q.valid <= en_pri_q[irq_pkg::EN_GATE] && found && preempt_ok && !cpu_ack;
            irq_q.num <= best_num;
            irq_q.vector <= irq_pkg::VEC_BASE + 16'({best_num, 3'b000});
            grant_lvl_q <= best_lvl;
        end
    end

    // Levels in service; a return ends the highest one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_service_q <= 4'h0;
        end else if (clk_en) begin
            if (cpu_ack && irq_q.valid) begin
                in_service_q[grant_lvl_q] <= 1'b1;
            end else if (cpu_reti && have_active) begin
                in_service_q[top_active] <= 1'b0;
            end
        end
    end

    // Halt wake-up and refusal; neither looks at the global gate or the pin-change enable
    logic wake_d, refuse_d;
    assign refuse_d = (en_pri_q[irq_pkg::EN_EX0] && !ext_irq_pin_a)
        || (en_pri_q[irq_pkg::EN_EX1] && !ext_irq_pin_b);
    assign wake_d = refuse_d || any_chg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
            refuse_q <= 1'b0;
            pwr_q <= irq_pkg::PWR_RUN;
        end else if (clk_en) begin
            wake_q <= wake_d;
            refuse_q <= power_down_request && refuse_d;
            case (pwr_q)
                irq_pkg::PWR_RUN: begin
                    if (power_down_request && !refuse_d) pwr_q <= irq_pkg::PWR_HALT;
                end
                irq_pkg::PWR_HALT: begin
                    if (wake_d) pwr_q <= irq_pkg::PWR_RUN;
                end
                default: pwr_q <= irq_pkg::PWR_RUN;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_out = irq_q;
    assign wake_out = wake_q;
    assign halt_refused = refuse_q;
    assign halted = (pwr_q == irq_pkg::PWR_HALT);
    assign low_voltage_threshold = lvd_q[3:0];
    assign timer_run = {timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TR1], timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_TR0]};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_GATE_BLOCKS: assert property ((clk_en && !en_pri_q[irq_pkg::EN_GATE]) |=> !irq_q.valid)
        else $error("request shown while global gate is low");
    AST_WAKE_NO_GATE: assert property ((clk_en && en_pri_q[irq_pkg::EN_EX0] && !ext_irq_pin_a) |=> wake_q)
        else $error("enabled low pin did not wake");
    AST_HALT_REFUSED: assert property ((clk_en && pwr_q == irq_pkg::PWR_RUN && power_down_request
        && en_pri_q[irq_pkg::EN_EX1] && !ext_irq_pin_b) |=> (pwr_q == irq_pkg::PWR_RUN) && refuse_q)
        else $error("halt entered while enabled pin low");
    AST_EDGE_SETS: assert property ((clk_en && pin_a_prev_q && !ext_irq_pin_a) |=> timer_extpin_control_q[irq_pkg::TIMER_EXTPIN_CONTROL_IE0])
        else $error("falling edge did not set flag");
    AST_NO_EQUAL_PREEMPT: assert property (irq_q.valid && $past(have_active)
        |-> grant_lvl_q > $past(top_active))
        else $error("request shown without strictly higher priority");
    AST_LVD_CLEAR: assert property ((wr_shared && wbyte == irq_pkg::LVD_CLEAR_VALUE && !low_voltage_evt)
        |=> !shared_q[irq_pkg::SH_LOW_VOLTAGE_FLAG] && shared_q[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG] == $past(shared_q[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG] | sh_set[irq_pkg::SH_PIN_CHANGE_SUMMARY_FLAG]))
        else $error("low-voltage clear wrong");
    AST_PIN_CHANGE_SUMMARY_FLAG_CLEARS_ALL: assert property ((clr_all_chg && !any_chg) |=> port_flags_q == irq_pkg::REG_RESET
        && pin_flag_q == '0)
        else $error("summary clear left change flags");
    AST_VECTOR: assert property (irq_q.valid |-> irq_q.num != irq_pkg::SRC_RESERVED
        && irq_q.vector == irq_pkg::VEC_BASE + 16'({irq_q.num, 3'b000}))
        else $error("bad vector or reserved source");
    AST_READY_PULSE: assert property (pready_q && clk_en |=> !pready_q)
        else $error("ready held longer than one cycle");
endmodule // irq_ctrl
`default_nettype wire

// [cpu_stub.sv]
// Core stand-in that takes offered interrupts and returns from them
`timescale 1ns/1ns
`default_nettype none
module cpu_stub (
    input wire logic pclk,
    input wire logic presetn,
    input wire irq_pkg::irq_grant_t irq_out,
    input wire logic go,
    input wire logic ret,
    output logic cpu_ack,
    output logic cpu_reti,
    output logic [3:0] took
);
    // Ack is a lone pulse so one grant is never taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_reti <= 1'b0;
            took <= 4'h0;
        end else begin
            cpu_ack <= go && irq_out.valid && !cpu_ack;
            cpu_reti <= ret;
            if (cpu_ack) begin
                took <= irq_out.num;
            end
        end
    end
endmodule // cpu_stub
`default_nettype wire

// [irq_priority_and_pin_events_tb_top.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module irq_priority_and_pin_events_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pa = 1, pb = 1, e;
    logic ack, reti, go = 0, ret = 0, t0 = 0, lve = 0, pd = 0, pready, pslverr, refused, halted;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] took, thr;
    logic wake;
    logic [13:0] z = '0;
    logic [3:0][7:0] pins = '1;
    irq_pkg::irq_grant_t irq;
    int failures = 0, compares = 0, cyc = 0;
    logic [7:0] q;
    logic [7:0] rows [7][3] = '{'{8'hA9, 8'hFF, 8'hFF}, '{8'hB8, 8'hFF, 8'h3F}, '{8'hB9, 8'hFF, 8'h3F},
        '{8'hBA, 8'hFF, 8'hFF}, '{8'hBB, 8'hFF, 8'hFF}, '{8'h91, 8'h03, 8'h03}, '{8'hBF, 8'hFF, 8'h9F}};
    irq_ctrl DUT (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_irq_pin_a(pa), .ext_irq_pin_b(pb), .port_pins(pins), .timer0_evt(t0),
        .timer1_evt(z[0]), .timer3_evt(z[1]), .adc_evt(z[2]), .eep_done_evt(z[3]), .eep_busy(z[4]),
        .low_voltage_evt(lve), .low_voltage_level(z[5]), .uart1_req(z[6]), .timer2_req(z[7]),
        .uart2_req(z[8]), .i2c_req(z[9]), .pwm_flags(z[11:10]), .pwm_chan_sub_enable(z[13:12]),
        .cpu_ack(ack), .cpu_reti(reti), .power_down_request(pd), .irq_out(irq), .wake_out(wake),
        .halt_refused(refused), .halted, .low_voltage_threshold(thr), .timer_run());
    cpu_stub core (.pclk, .presetn, .irq_out(irq), .go, .ret, .cpu_ack(ack), .cpu_reti(reti), .took);
    always #25 pclk = ~pclk;
    task automatic give_verdict();
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Limit covers every scenario with wide margin
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(0, rows[i][0], 8'h00);
            chk(q, 8'h00);
            apb(1, rows[i][0], rows[i][1]);
            apb(0, rows[i][0], 8'h00);
            chk(q, rows[i][2]);
        end
        chk(thr, 4'hF);
        apb(1, 8'h91, 8'h02);
        apb(0, 8'h91, 8'h00);
        chk(q, 8'h03);
        apb(0, 8'h00, 8'h00);
        chk({e, q}, 9'h100);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'hA9, 8'h00);
        chk(q, 8'h00);
        apb(1, 8'h88, 8'h01);
        apb(1, 8'hB9, 8'h02);
        apb(1, 8'hB8, 8'h02);
        apb(1, 8'hA8, 8'h03);
        pa <= 0;
        t0 <= 1;
        @(posedge pclk);
        t0 <= 0;
        repeat (3) @(posedge pclk);
        chk(irq.valid, 1'b0);
        apb(0, 8'h88, 8'h00);
        chk(q, 8'h23);
        apb(1, 8'hA8, 8'h83);
        repeat (2) @(posedge pclk);
        chk(irq, {1'b1, 4'h1, 16'h000B});
        go <= 1;
        repeat (4) @(posedge pclk);
        go <= 0;
        chk(took, 4'h1);
        chk(irq.valid, 1'b0);
        apb(1, 8'h88, 8'h03);
        ret <= 1;
        @(posedge pclk);
        ret <= 0;
        repeat (3) @(posedge pclk);
        chk(irq, {1'b1, 4'h0, 16'h0003});
        go <= 1;
        repeat (4) @(posedge pclk);
        go <= 0;
        apb(0, 8'h88, 8'h00);
        chk(q, 8'h01);
        lve <= 1;
        @(posedge pclk);
        lve <= 0;
        apb(1, 8'h95, 8'hFF);
        apb(0, 8'h95, 8'h00);
        chk(q, 8'h80);
        apb(1, 8'h95, 8'h7F);
        apb(0, 8'h95, 8'h00);
        chk(q, 8'h00);
        apb(1, 8'hA8, 8'h01);
        pd <= 1;
        @(posedge pclk);
        pd <= 0;
        @(posedge pclk);
        chk({refused, halted}, 2'b10);
        pa <= 1;
        pd <= 1;
        @(posedge pclk);
        pd <= 0;
        @(posedge pclk);
        chk({refused, halted}, 2'b01);
        pa <= 0;
        repeat (4) @(posedge pclk);
        chk(halted, 1'b0);
        pa <= 1;
        apb(1, 8'hC0, 8'h08);
        pins[0][0] <= 0;
        repeat (2) @(posedge pclk);
        chk(wake, 1'b1);
        apb(0, 8'h95, 8'h00);
        chk(q, 8'h00);
        apb(0, 8'h85, 8'h00);
        chk(q, 8'h01);
        apb(0, 8'h96, 8'h00);
        chk(q, 8'h01);
        apb(1, 8'hA9, 8'h02);
        pins[0][0] <= 1;
        apb(0, 8'h95, 8'h00);
        chk(q, 8'h02);
        apb(1, 8'h95, 8'hFD);
        apb(0, 8'h85, 8'h00);
        chk(q, 8'h00);
        apb(0, 8'h96, 8'h00);
        chk(q, 8'h00);
        give_verdict();
    end
endmodule // irq_priority_and_pin_events_tb_top
`default_nettype wire
